// ### verilog/ssi_enc_map.svh
`ifndef SSI_ENC_MAP_SVH
`define SSI_ENC_MAP_SVH
// system clock
`define CLK_PERIOD_NS    100
// message update gap and its cycle count
`define UPDATE_GAP_NS    20000
`define UPDATE_GAP_CYC   (`UPDATE_GAP_NS / `CLK_PERIOD_NS)
// controller pause between frames, longer than the update gap
`define PAUSE_NS         25000
`define PAUSE_CYC        (`PAUSE_NS / `CLK_PERIOD_NS)
// capture tick step
`define TICK_NS          10000
`define TICK_CYC         (`TICK_NS / `CLK_PERIOD_NS)
// zero strap hold time at power-up
`define ZERO_HOLD_MS     5000
`define ZERO_HOLD_CYC    (`ZERO_HOLD_MS * (1000000 / `CLK_PERIOD_NS))
// serial clock half period made by the controller, in system cycles
`define SCLK_HALF_CYC    8
// message lengths
`define LEN_ONE          24
`define LEN_TWO          24
`define LEN_THREE        16
`define LEN_FOUR         32
`define LEN_FIVE         16
// field positions
`define F1_VALID_POS     23
`define F1_ORIGIN_POS    22
`define F2_ANGLE_LSB     2
`define F2_PARITY_POS    1
`define F2_ERROR_POS     0
`define F4_VALID_POS     31
`define F4_ORIGIN_POS    30
`define F4_ANGLE_LSB     11
`define ANGLE_W          22
`define ANGLE4_W         19
`define TICK_W           11
// controller register offsets
`define REG_CTRL         32'h0000_0000
`define REG_STATUS       32'h0000_0004
`define REG_DATA         32'h0000_0008
// controller register fields
`define CTRL_START_BIT   0
`define CTRL_FMT_LSB     1
`define STAT_BUSY_BIT    0
`define STAT_DONE_BIT    1
`define STAT_ERR_BIT     2
// reset values
`define CTRL_RESET       3'h1
`define FACTORY_ZERO     22'h000000
`endif

// ### verilog/ssi_enc_pkg.sv
package ssi_enc_pkg;
  typedef enum logic [2:0] {
    FMT_ONE   = 3'h1,
    FMT_TWO   = 3'h2,
    FMT_THREE = 3'h3,
    FMT_FOUR  = 3'h4,
    FMT_FIVE  = 3'h5
  } frame_fmt_t;

  typedef enum logic [1:0] {
    DEV_IDLE  = 2'h0,
    DEV_SHIFT = 2'h1,
    DEV_GAP   = 2'h2
  } dev_state_t;

  typedef enum logic [1:0] {
    CTL_IDLE  = 2'h0,
    CTL_LOW   = 2'h1,
    CTL_HIGH  = 2'h2,
    CTL_TAIL  = 2'h3
  } ctl_state_t;
endpackage

// ### verilog/ssi_link_if.sv
`timescale 1ns/1ps
interface ssi_link_if;
  logic sclk;
  logic sdata;
  modport device (input sclk, output sdata);
  modport ctrl   (output sclk, input sdata);
endinterface

// ### verilog/ssi_encoder_end.sv
// Behaviour
// - idle: clock high, data high
// - controller clock between 100 kHz and 2 MHz
// - read cycle is n periods plus half
// - pause between frames exceeds update gap
// - first falling edge after gap starts cycle
// - each rising edge presents next bit, MSB first
// - error flag driven after final rising edge
// - latest position offered after update gap
// - bit count excludes trailing error flag
// - format one: valid, origin, 22-bit binary angle
// - origin flag high while zero is factory
// - unused upper angle bits zero, LSB at 0
// - format two: angle, even parity, error bit
// - parity bit set for odd ones count
// - error bit high on error condition
// - format three: 16-bit binary angle
// - format four: valid, origin, angle, tick
// - tick counter 10 us steps, wraps at 20.47 ms
// - format five: 16-bit Gray angle
// - zero set stores position, zero reset restores
// - strap held low five seconds at power-up
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ssi_enc_map.svh"
module ssi_encoder_end #(
  parameter int unsigned ZERO_HOLD_CYC = `ZERO_HOLD_CYC
) (
  input  wire logic          clock_in,
  input  wire logic          rst_b_in,
  ssi_link_if.device         link,
  input  wire logic [21:0]   angle_raw_in,
  input  wire logic          angle_strobe_in,
  input  wire logic          error_in,
  input  wire logic [2:0]    format_in,
  input  wire logic [4:0]    res_bits_in,
  input  wire logic          zero_set_b_in,
  input  wire logic          zero_reset_b_in,
  input  wire logic [21:0]   nv_zero_in,
  input  wire logic          nv_default_in,
  output logic               nv_write_out,
  output logic [21:0]        nv_zero_out,
  output logic               nv_default_out
);
  localparam logic [7:0]  GAP_CYC  = 8'(`UPDATE_GAP_CYC);
  localparam logic [6:0]  TICK_CYC = 7'(`TICK_CYC);
  localparam logic [25:0] HOLD_CYC = 26'(ZERO_HOLD_CYC);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: serial clock and the two zero straps
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] async_w;
  assign async_w = {zero_reset_b_in, zero_set_b_in, link.sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sync1_reg[gi] <= 1'b1;
          sync2_reg[gi] <= 1'b1;
        end else begin
          sync1_reg[gi] <= async_w[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic sclk_prev_reg;
  logic sclk_fall_w;
  logic sclk_rise_w;
  assign sclk_fall_w = sclk_prev_reg & ~sync2_reg[0];
  assign sclk_rise_w = ~sclk_prev_reg & sync2_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // capture tick counter and position capture
  logic [6:0]  presc_reg;
  logic [10:0] tick_reg;
  logic [21:0] pos_reg;
  logic [10:0] pos_tick_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      presc_reg    <= 7'h00;
      tick_reg     <= 11'h000;
      pos_reg      <= 22'h000000;
      pos_tick_reg <= 11'h000;
    end else begin
      presc_reg <= (presc_reg == TICK_CYC - 7'h01) ? 7'h00 : presc_reg + 7'h01;
      if (presc_reg == TICK_CYC - 7'h01) begin
        tick_reg <= tick_reg + 11'h001;
      end
      if (angle_strobe_in) begin
        pos_reg      <= angle_raw_in;
        pos_tick_reg <= tick_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // zero point: loaded from storage, changed by straps at power-up
  logic [21:0] zero_reg;
  logic        default_reg;
  logic        loaded_reg;
  logic        armed_reg;
  logic [25:0] hold_reg;
  logic        nv_write_reg;
  logic        settle_reg;
  logic        strap_low_w;
  assign strap_low_w = ~sync2_reg[1] | ~sync2_reg[2];
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      zero_reg     <= `FACTORY_ZERO;
      default_reg  <= 1'b1;
      loaded_reg   <= 1'b0;
      armed_reg    <= 1'b1;
      hold_reg     <= 26'h0000000;
      nv_write_reg <= 1'b0;
      settle_reg   <= 1'b0;
    end else begin
      nv_write_reg <= 1'b0;
      loaded_reg   <= 1'b1;
      if (!loaded_reg) begin
        zero_reg    <= nv_zero_in;
        default_reg <= nv_default_in;
      end else if (!settle_reg) begin
        settle_reg <= 1'b1; // strap synchronisers still carry their reset level
      end else if (armed_reg) begin
        if (!strap_low_w) begin
          armed_reg <= 1'b0; // straps only honoured from power-up
        end else if (hold_reg == HOLD_CYC - 26'h0000001) begin
          armed_reg    <= 1'b0;
          nv_write_reg <= 1'b1;
          if (!sync2_reg[1]) begin
            zero_reg    <= angle_raw_in;
            default_reg <= 1'b0;
          end else begin
            zero_reg    <= `FACTORY_ZERO;
            default_reg <= 1'b1;
          end
        end else begin
          hold_reg <= hold_reg + 26'h0000001;
        end
      end
    end
  end
  assign nv_write_out   = nv_write_reg;
  assign nv_zero_out    = zero_reg;
  assign nv_default_out = default_reg;

  ////////////////////////////////////////////////////////////////////////
  // frame assembly for the selected format
  logic [4:0]  res_w;
  logic [21:0] mask_w;
  logic [21:0] angle_w;
  logic [15:0] a16_w;
  logic [31:0] frame_w;
  logic [5:0]  len_w;
  assign res_w   = (res_bits_in > 5'd22) ? 5'd22 : res_bits_in;
  assign mask_w  = 22'((23'h000001 << res_w) - 23'h000001);
  assign angle_w = (pos_reg - zero_reg) & mask_w;
  assign a16_w   = angle_w[15:0];

  always_comb begin
    frame_w = 32'h0000_0000;
    len_w   = 6'(`LEN_ONE);
    unique case (format_in)
      ssi_enc_pkg::FMT_TWO: begin
        frame_w[23:`F2_ANGLE_LSB]  = angle_w;
        frame_w[`F2_PARITY_POS]    = ^angle_w;
        frame_w[`F2_ERROR_POS]     = error_in;
        len_w = 6'(`LEN_TWO);
      end
      ssi_enc_pkg::FMT_THREE: begin
        frame_w[15:0] = a16_w;
        len_w = 6'(`LEN_THREE);
      end
      ssi_enc_pkg::FMT_FOUR: begin
        frame_w[`F4_VALID_POS]    = ~error_in;
        frame_w[`F4_ORIGIN_POS]   = default_reg;
        frame_w[29:`F4_ANGLE_LSB] = angle_w[18:0];
        frame_w[10:0]             = pos_tick_reg;
        len_w = 6'(`LEN_FOUR);
      end
      ssi_enc_pkg::FMT_FIVE: begin
        frame_w[15:0] = a16_w ^ {1'b0, a16_w[15:1]};
        len_w = 6'(`LEN_FIVE);
      end
      default: begin
        frame_w[`F1_VALID_POS]  = ~error_in;
        frame_w[`F1_ORIGIN_POS] = default_reg;
        frame_w[21:0]           = angle_w;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output state machine
  ssi_enc_pkg::dev_state_t state_reg;
  logic [31:0] frame_reg;
  logic [5:0]  len_reg;
  logic [5:0]  rise_reg;
  logic [7:0]  gap_reg;
  logic        err_reg;
  logic        data_reg;
  logic        last_rise_w;
  assign last_rise_w = (rise_reg == len_reg);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg     <= ssi_enc_pkg::DEV_IDLE;
      sclk_prev_reg <= 1'b1;
      frame_reg     <= 32'h0000_0000;
      len_reg       <= 6'h00;
      rise_reg      <= 6'h00;
      gap_reg       <= 8'h00;
      err_reg       <= 1'b0;
      data_reg      <= 1'b1;
    end else begin
      sclk_prev_reg <= sync2_reg[0];
      unique case (state_reg)
        ssi_enc_pkg::DEV_IDLE: begin
          data_reg <= 1'b1;
          if (sclk_fall_w) begin
            frame_reg <= frame_w;
            len_reg   <= len_w;
            err_reg   <= error_in;
            rise_reg  <= 6'h00;
            gap_reg   <= 8'h00;
            state_reg <= ssi_enc_pkg::DEV_SHIFT;
          end
        end
        ssi_enc_pkg::DEV_SHIFT: begin
          gap_reg <= sclk_fall_w ? 8'h00 : gap_reg + 8'h01;
          if (sclk_rise_w) begin
            if (last_rise_w) begin
              data_reg  <= err_reg;
              state_reg <= ssi_enc_pkg::DEV_GAP;
            end else begin
              data_reg <= frame_reg[5'(len_reg - rise_reg - 6'h01)];
              rise_reg <= rise_reg + 6'h01;
            end
          end else if (gap_reg >= GAP_CYC - 8'h01) begin
            data_reg  <= 1'b1;
            state_reg <= ssi_enc_pkg::DEV_IDLE; // cut frame: give up after the gap
          end
        end
        ssi_enc_pkg::DEV_GAP: begin
          if (gap_reg >= GAP_CYC - 8'h01) begin
            data_reg  <= 1'b1;
            state_reg <= ssi_enc_pkg::DEV_IDLE;
          end else begin
            gap_reg <= gap_reg + 8'h01;
          end
        end
        default: state_reg <= ssi_enc_pkg::DEV_IDLE;
      endcase
    end
  end
  assign link.sdata = data_reg;
endmodule

// ### verilog/ssi_master_end.sv
`timescale 1ns/1ps
`include "ssi_enc_map.svh"
module ssi_master_end (
  input  wire logic          clock_in,
  input  wire logic          rst_b_in,
  ssi_link_if.ctrl           link,
  input  wire logic          hsel_in,
  input  wire logic [31:0]   haddr_in,
  input  wire logic [1:0]    htrans_in,
  input  wire logic          hwrite_in,
  input  wire logic [2:0]    hsize_in,
  input  wire logic [31:0]   hwdata_in,
  input  wire logic          hready_in,
  output logic [31:0]        hrdata_out,
  output logic               hreadyout_out,
  output logic               hresp_out
);
  localparam logic [3:0] HALF_CYC  = 4'(`SCLK_HALF_CYC);
  localparam logic [7:0] PAUSE_CYC = 8'(`PAUSE_CYC);

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: address phase capture, single-cycle data phase
  logic        wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic        take_w;
  logic        wr_ctrl_w;
  logic        wr_stat_w;
  assign take_w    = hsel_in & htrans_in[1] & hready_in;
  assign wr_ctrl_w = wr_pend_reg & (wr_addr_reg == `REG_CTRL);
  assign wr_stat_w = wr_pend_reg & (wr_addr_reg == `REG_STATUS);
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // link synchroniser for returning data
  logic data_s1_reg;
  logic data_s2_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_s1_reg <= 1'b1;
      data_s2_reg <= 1'b1;
    end else begin
      data_s1_reg <= link.sdata;
      data_s2_reg <= data_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and read mux
  logic [2:0]  fmt_reg;
  logic        pend_reg;
  logic        done_reg;
  logic        err_reg;
  logic [31:0] data_reg;
  logic        busy_w;
  logic        frame_end_w;
  logic [5:0]  len_w;
  logic [31:0] stat_w;
  logic [31:0] rmux_w;
  ssi_enc_pkg::ctl_state_t state_reg;
  assign busy_w = (state_reg != ssi_enc_pkg::CTL_IDLE) | pend_reg;
  assign stat_w = {29'h0, err_reg, done_reg, busy_w};
  assign rmux_w = (haddr_in == `REG_CTRL)   ? {28'h0, fmt_reg, 1'b0} :
                  (haddr_in == `REG_STATUS) ? stat_w :
                  (haddr_in == `REG_DATA)   ? data_reg : 32'h0000_0000;
  assign len_w  = (fmt_reg == ssi_enc_pkg::FMT_FOUR) ? 6'(`LEN_FOUR) :
                  (fmt_reg == ssi_enc_pkg::FMT_THREE ||
                   fmt_reg == ssi_enc_pkg::FMT_FIVE) ? 6'(`LEN_THREE) : 6'(`LEN_ONE);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      rdata_reg   <= 32'h0000_0000;
      fmt_reg     <= `CTRL_RESET;
      pend_reg    <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      wr_pend_reg <= take_w & hwrite_in;
      if (take_w) begin
        wr_addr_reg <= haddr_in;
      end
      if (take_w & ~hwrite_in) begin
        rdata_reg <= rmux_w;
      end
      if (wr_ctrl_w && !busy_w) begin
        fmt_reg  <= hwdata_in[`CTRL_FMT_LSB +: 3];
        pend_reg <= hwdata_in[`CTRL_START_BIT];
      end else if (state_reg == ssi_enc_pkg::CTL_LOW) begin
        pend_reg <= 1'b0;
      end
      // completion wins over a software clear in the same cycle
      if (frame_end_w) begin
        done_reg <= 1'b1;
      end else if (wr_stat_w && hwdata_in[`STAT_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial clock generator and receiver
  logic       sclk_reg;
  logic [3:0] half_reg;
  logic [5:0] rise_reg;
  logic [7:0] pause_reg;
  logic       half_end_w;
  assign half_end_w  = (half_reg == HALF_CYC - 4'h1);
  assign frame_end_w = (state_reg == ssi_enc_pkg::CTL_TAIL) & half_end_w;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ssi_enc_pkg::CTL_IDLE;
      sclk_reg  <= 1'b1;
      half_reg  <= 4'h0;
      rise_reg  <= 6'h00;
      pause_reg <= 8'h00;
      err_reg   <= 1'b0;
      data_reg  <= 32'h0000_0000;
    end else begin
      half_reg <= half_end_w ? 4'h0 : half_reg + 4'h1;
      unique case (state_reg)
        ssi_enc_pkg::CTL_IDLE: begin
          sclk_reg <= 1'b1;
          half_reg <= 4'h0;
          if (pause_reg != PAUSE_CYC) begin
            pause_reg <= pause_reg + 8'h01;
          end else if (pend_reg) begin
            sclk_reg  <= 1'b0;
            rise_reg  <= 6'h00;
            data_reg  <= 32'h0000_0000;
            state_reg <= ssi_enc_pkg::CTL_LOW;
          end
        end
        ssi_enc_pkg::CTL_LOW: begin
          if (half_end_w) begin
            sclk_reg  <= 1'b1;
            rise_reg  <= rise_reg + 6'h01;
            state_reg <= (rise_reg == len_w) ? ssi_enc_pkg::CTL_TAIL
                                             : ssi_enc_pkg::CTL_HIGH;
          end
        end
        ssi_enc_pkg::CTL_HIGH: begin
          if (half_end_w) begin
            sclk_reg  <= 1'b0;
            data_reg  <= {data_reg[30:0], data_s2_reg};
            state_reg <= ssi_enc_pkg::CTL_LOW;
          end
        end
        ssi_enc_pkg::CTL_TAIL: begin
          if (half_end_w) begin
            err_reg   <= data_s2_reg;
            pause_reg <= 8'h00;
            state_reg <= ssi_enc_pkg::CTL_IDLE;
          end
        end
        default: state_reg <= ssi_enc_pkg::CTL_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_reg;
endmodule

// ### tb/ssi_angle_encoder_output_monitor.sv
`timescale 1ns/1ps
module ssi_angle_encoder_output_monitor (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic sclk,
  input wire logic sdata
);
  logic       sclk_q;
  logic [7:0] idle_cnt;
  logic [3:0] rise_cnt;
  logic [5:0] rise_tot;
  wire        fall_w = sclk_q & ~sclk;
  wire        rise_w = ~sclk_q & sclk;

  ////////////////////////////////////////////////////////////////////////////////
  // cycles since last fall and last rise, rises in the current frame
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_q   <= 1'b1;
      idle_cnt <= 8'hff;
      rise_cnt <= 4'hf;
      rise_tot <= 6'h00;
    end else begin
      sclk_q   <= sclk;
      idle_cnt <= fall_w ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hff};
      rise_cnt <= rise_w ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hf};
      rise_tot <= (fall_w && idle_cnt > 8'd20) ? 6'h00 : rise_tot + {5'h00, rise_w};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link timing and framing
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  property p_idle_data; (sclk && idle_cnt > 8'd212) |-> sdata; endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("data not high in idle");
  property p_gap_end; (sclk && idle_cnt == 8'd190) |-> ##[1:22] sdata; endproperty
  a_gap_end: assert property (p_gap_end)
    else $error("data not released after update gap");
  property p_change_win;
    $changed(sdata) |-> (rise_cnt <= 4'd5 || (idle_cnt >= 8'd195 && idle_cnt <= 8'd212));
  endproperty
  a_change_win: assert property (p_change_win)
    else $error("data changed away from a clock rise");
  property p_flag_hold; (idle_cnt >= 8'd20 && idle_cnt <= 8'd190) |-> $stable(sdata); endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("error flag not held through gap");
  property p_low_half; fall_w |-> !sclk [*8] ##1 sclk; endproperty
  a_low_half: assert property (p_low_half)
    else $error("clock low phase wrong length");
  property p_high_half; rise_w |-> sclk [*8]; endproperty
  a_high_half: assert property (p_high_half)
    else $error("clock high phase too short");
  property p_pause; fall_w |-> (idle_cnt <= 8'd16 || idle_cnt > 8'd200); endproperty
  a_pause: assert property (p_pause)
    else $error("pause between frames too short");
  property p_rise_count;
    (idle_cnt == 8'd20) |-> (rise_tot == 6'd17 || rise_tot == 6'd25 || rise_tot == 6'd33);
  endproperty
  a_rise_count: assert property (p_rise_count)
    else $error("wrong number of clock rises in frame");
  property p_low_still; !sclk |-> $stable(sdata); endproperty
  a_low_still: assert property (p_low_still)
    else $error("data moved while clock low");
endmodule

// ### tb/test_ssi_angle_encoder_output.sv
`timescale 1ns/1ps
module test_ssi_angle_encoder_output;
  logic        clock_in, rst_b_in, strobe, err, zs_b, zr_b, nv_dflt, nv_wr, nv_dflt_o;
  logic [21:0] angle_raw, nv_zero, nv_zero_o;
  logic [2:0]  fmt;
  logic [4:0]  res;
  logic [31:0] haddr, hwdata, hrdata, rd, st;
  logic [1:0]  htrans;
  logic        hwrite, hready, hresp;
  logic [10:0] tick_a;
  int          errors, cmp_count, cyc, t0;

  ssi_link_if link ();
  ssi_encoder_end #(.ZERO_HOLD_CYC(20)) i_ssi_encoder_end (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .link(link), .angle_raw_in(angle_raw),
    .angle_strobe_in(strobe), .error_in(err), .format_in(fmt), .res_bits_in(res),
    .zero_set_b_in(zs_b), .zero_reset_b_in(zr_b), .nv_zero_in(nv_zero),
    .nv_default_in(nv_dflt), .nv_write_out(nv_wr), .nv_zero_out(nv_zero_o),
    .nv_default_out(nv_dflt_o));
  ssi_master_end i_ssi_master_end (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .link(link), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp));
  ssi_angle_encoder_output_monitor i_ssi_angle_encoder_output_monitor (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .sclk(link.sclk), .sdata(link.sdata));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, cycle count, nonvolatile store
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (nv_wr === 1'b1) begin
      nv_zero <= nv_zero_o;
      nv_dflt <= nv_dflt_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_ready;
    @(posedge clock_in);
    while (hready !== 1'b1) begin
      @(posedge clock_in);
    end
  endtask
  // one single word transfer, read data left in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask
  task automatic set_angle(input logic [21:0] a);
    angle_raw <= a;
    strobe    <= 1'b1;
    @(posedge clock_in);
    strobe    <= 1'b0;
    t0 = cyc;
    @(posedge clock_in);
  endtask
  // start a frame, wait for done, read and judge the received word
  task automatic frame(input logic [2:0] f, input logic [31:0] mask, input logic [31:0] exp,
                       input string name);
    fmt <= f;
    ahb(1'b1, 32'h0, {28'h0, f, 1'b1});
    rd = 32'h0;
    while (rd[1] !== 1'b1) begin
      ahb(1'b0, 32'h4, 32'h0);
    end
    st = rd;
    ahb(1'b0, 32'h8, 32'h0);
    check(name, rd & mask, exp);
    ahb(1'b1, 32'h4, 32'h2);
  endtask
  task automatic do_reset(input logic s_b, input logic r_b);
    zs_b     <= s_b;
    zr_b     <= r_b;
    rst_b_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (40) @(posedge clock_in);
    zs_b     <= 1'b1;
    zr_b     <= 1'b1;
    repeat (2) @(posedge clock_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_formats(input logic [21:0] a);
    res <= 5'd22;
    set_angle(a);
    frame(ssi_enc_pkg::FMT_ONE, 32'hffffffff, {8'h0, 2'b11, a}, "fmt one");
    frame(ssi_enc_pkg::FMT_TWO, 32'hffffffff, {8'h0, a, ^a, 1'b0}, "fmt two");
    check("status err", {31'h0, st[2]}, 32'h0);
    frame(ssi_enc_pkg::FMT_THREE, 32'hffffffff, {16'h0, a[15:0]}, "fmt three");
    frame(ssi_enc_pkg::FMT_FIVE, 32'hffffffff, {16'h0, a[15:0] ^ (a[15:0] >> 1)},
          "fmt five");
  endtask
  task automatic sc_resolution;
    res <= 5'd12;
    set_angle(22'h2abcde);
    frame(ssi_enc_pkg::FMT_ONE, 32'hffffffff, 32'h00c00cde, "low res");
    res <= 5'd22;
  endtask
  task automatic sc_error;
    err <= 1'b1;
    set_angle(22'h155555);
    frame(ssi_enc_pkg::FMT_TWO, 32'h1, 32'h1, "error bit");
    check("status err", {31'h0, st[2]}, 32'h1);
    frame(ssi_enc_pkg::FMT_ONE, 32'h00c00000, 32'h00400000, "valid low");
    err <= 1'b0;
  endtask
  task automatic sc_tick;
    set_angle(22'h03a5a5);
    frame(ssi_enc_pkg::FMT_FOUR, 32'hfffff800, {2'b11, 19'h03a5a5, 11'h0}, "fmt four");
    tick_a = rd[10:0];
    while (cyc < t0 + 1999) @(posedge clock_in);
    set_angle(22'h03a5a6);
    frame(ssi_enc_pkg::FMT_FOUR, 32'hfffff800, {2'b11, 19'h03a5a6, 11'h0}, "latest");
    check("tick step", {21'h0, rd[10:0] - tick_a}, 32'd20);
  endtask
  task automatic sc_zero;
    do_reset(1'b0, 1'b1);
    check("zero stored", {10'h0, nv_zero_o}, 32'h02abcd);
    check("origin flag", {31'h0, nv_dflt_o}, 32'h0);
    set_angle(22'h02abce);
    frame(ssi_enc_pkg::FMT_ONE, 32'hffffffff, 32'h00800001, "after set");
    do_reset(1'b1, 1'b0);
    check("zero cleared", {10'h0, nv_zero_o}, 32'h0);
    set_angle(22'h02abce);
    frame(ssi_enc_pkg::FMT_ONE, 32'hffffffff, 32'h00c2abce, "after reset");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    {strobe, err, htrans, hwrite, haddr, hwdata, cyc, t0, errors, cmp_count} = '0;
    {rst_b_in, zs_b, zr_b, nv_dflt} = 4'h7;
    {angle_raw, nv_zero, fmt, res} = {22'h02abcd, 22'h0, 3'h1, 5'd22};
    do_reset(1'b1, 1'b1);
    check("origin reset", {31'h0, nv_dflt_o}, 32'h1);
    ahb(1'b1, 32'h10, 32'hffffffff);
    sc_formats(22'h2abcde);
    sc_formats(22'h2abcdf);
    sc_resolution;
    sc_error;
    sc_tick;
    angle_raw <= 22'h02abcd;
    sc_zero;
    finish_test;
  end
  initial begin
    #4000000;
    errors++;
    finish_test;
  end
endmodule
